// ---- logic/owg_consts.vh ----
// Register map and field widths of the window geometry register block.
`ifndef OWG_CONSTS_VH
`define OWG_CONSTS_VH
`define OWG_ADDR_W        4
`define OWG_V1_YSTART     4'h0
`define OWG_V1_WIDTH      4'h1
`define OWG_V1_HEIGHT     4'h2
`define OWG_B0_XSTART     4'h3
`define OWG_B0_YSTART     4'h4
`define OWG_B0_WIDTH      4'h5
`define OWG_B0_HEIGHT     4'h6
`define OWG_B1_XSTART     4'h7
`define OWG_B1_YSTART     4'h8
`define OWG_B1_WIDTH      4'h9
`define OWG_B1_HEIGHT     4'ha
`define OWG_CUR_XSTART    4'hb
`define OWG_CUR_YSTART    4'hc
`define OWG_CUR_WIDTH     4'hd
`define OWG_CUR_HEIGHT    4'he
`define OWG_BASE_X        4'hf
`define OWG_XPOS_W        10
`define OWG_YPOS_W        9
`define OWG_XLEN_W        12
`define OWG_YLEN_W        11
`define OWG_CNT_W         13
`define OWG_RESET_VAL     32'h0000_0000
`endif

// ---- logic/owg_window_geometry.v ----
// Window geometry registers with vertical-sync shadowing and hit tests.
`include "owg_consts.vh"
`default_nettype none
module owg_window_geometry
(
    // Clock and reset.
    input  wire                       core_clk,
    input  wire                       resetn,
    // Register port.
    input  wire [`OWG_ADDR_W-1:0]     reg_addr,
    input  wire [31:0]                reg_wdata,
    input  wire                       reg_write,
    input  wire                       reg_read,
    output reg  [31:0]                reg_rdata,
    // Display timing.
    input  wire                       vertical_sync_event,
    input  wire [`OWG_YPOS_W-1:0]     vertical_base_reference,
    input  wire [`OWG_CNT_W-1:0]      pixel_column,
    input  wire [`OWG_CNT_W-1:0]      pixel_line,
    // Active geometry.
    output reg  [`OWG_YPOS_W-1:0]     video1_line_offset,
    output reg  [`OWG_XLEN_W-1:0]     video1_pixel_width,
    output reg  [`OWG_YLEN_W-1:0]     video1_line_height,
    output reg  [`OWG_XPOS_W-1:0]     bitmap0_pixel_offset,
    output reg  [`OWG_YPOS_W-1:0]     bitmap0_line_offset,
    output reg  [`OWG_XLEN_W-1:0]     bitmap0_pixel_width,
    output reg  [`OWG_YLEN_W-1:0]     bitmap0_line_height,
    output reg  [`OWG_XPOS_W-1:0]     bitmap1_pixel_offset,
    output reg  [`OWG_YPOS_W-1:0]     bitmap1_line_offset,
    output reg  [`OWG_XLEN_W-1:0]     bitmap1_pixel_width,
    output reg  [`OWG_YLEN_W-1:0]     bitmap1_line_height,
    output reg  [`OWG_XPOS_W-1:0]     cursor_pixel_offset,
    output reg  [`OWG_YPOS_W-1:0]     cursor_line_offset,
    output reg  [`OWG_XLEN_W-1:0]     cursor_pixel_width,
    output reg  [`OWG_YLEN_W-1:0]     cursor_line_height,
    output reg  [`OWG_XPOS_W-1:0]     horizontal_base_reference,
    // Window hit flags for the current pixel.
    output wire                       video1_line_hit,
    output wire                       bitmap0_hit,
    output wire                       bitmap1_hit,
    output wire                       cursor_hit
);

    // Pending copies written by software.
    reg [`OWG_YPOS_W-1:0] v1_ys;
    reg [`OWG_XLEN_W-1:0] v1_w;
    reg [`OWG_YLEN_W-1:0] v1_h;
    reg [`OWG_XPOS_W-1:0] b0_xs;
    reg [`OWG_YPOS_W-1:0] b0_ys;
    reg [`OWG_XLEN_W-1:0] b0_w;
    reg [`OWG_YLEN_W-1:0] b0_h;
    reg [`OWG_XPOS_W-1:0] b1_xs;
    reg [`OWG_YPOS_W-1:0] b1_ys;
    reg [`OWG_XLEN_W-1:0] b1_w;
    reg [`OWG_YLEN_W-1:0] b1_h;
    reg [`OWG_XPOS_W-1:0] cu_xs;
    reg [`OWG_YPOS_W-1:0] cu_ys;
    reg [`OWG_XLEN_W-1:0] cu_w;
    reg [`OWG_YLEN_W-1:0] cu_h;
    reg [`OWG_XPOS_W-1:0] base_x;
    reg [31:0]            next_rdata;
    wire [`OWG_YPOS_W-1:0] eff_base_y;

    // Next values of the pending copies.
    reg [`OWG_YPOS_W-1:0] next_v1_ys;
    reg [`OWG_XLEN_W-1:0] next_v1_w;
    reg [`OWG_YLEN_W-1:0] next_v1_h;
    reg [`OWG_XPOS_W-1:0] next_b0_xs;
    reg [`OWG_YPOS_W-1:0] next_b0_ys;
    reg [`OWG_XLEN_W-1:0] next_b0_w;
    reg [`OWG_YLEN_W-1:0] next_b0_h;
    reg [`OWG_XPOS_W-1:0] next_b1_xs;
    reg [`OWG_YPOS_W-1:0] next_b1_ys;
    reg [`OWG_XLEN_W-1:0] next_b1_w;
    reg [`OWG_YLEN_W-1:0] next_b1_h;
    reg [`OWG_XPOS_W-1:0] next_cu_xs;
    reg [`OWG_YPOS_W-1:0] next_cu_ys;
    reg [`OWG_XLEN_W-1:0] next_cu_w;
    reg [`OWG_YLEN_W-1:0] next_cu_h;
    reg [`OWG_XPOS_W-1:0] next_base_x;

    // Next values of the active copies.
    reg [`OWG_YPOS_W-1:0] next_video1_line_offset;
    reg [`OWG_XLEN_W-1:0] next_video1_pixel_width;
    reg [`OWG_YLEN_W-1:0] next_video1_line_height;
    reg [`OWG_XPOS_W-1:0] next_bitmap0_pixel_offset;
    reg [`OWG_YPOS_W-1:0] next_bitmap0_line_offset;
    reg [`OWG_XLEN_W-1:0] next_bitmap0_pixel_width;
    reg [`OWG_YLEN_W-1:0] next_bitmap0_line_height;
    reg [`OWG_XPOS_W-1:0] next_bitmap1_pixel_offset;
    reg [`OWG_YPOS_W-1:0] next_bitmap1_line_offset;
    reg [`OWG_XLEN_W-1:0] next_bitmap1_pixel_width;
    reg [`OWG_YLEN_W-1:0] next_bitmap1_line_height;
    reg [`OWG_XPOS_W-1:0] next_cursor_pixel_offset;
    reg [`OWG_YPOS_W-1:0] next_cursor_line_offset;
    reg [`OWG_XLEN_W-1:0] next_cursor_pixel_width;
    reg [`OWG_YLEN_W-1:0] next_cursor_line_height;
    reg [`OWG_XPOS_W-1:0] next_horizontal_base_reference;

    // The vertical reference never falls below line one.
    assign eff_base_y = (vertical_base_reference == 9'h000) ?
                        9'h001 : vertical_base_reference;

    // Inside test on one axis: base + offset <= pos < base + offset + len.
    function in_span;
        input [`OWG_CNT_W-1:0] pos;
        input [`OWG_CNT_W-1:0] base;
        input [`OWG_CNT_W-1:0] offs;
        input [`OWG_CNT_W-1:0] len;
        reg   [`OWG_CNT_W+1:0] lo;
        reg   [`OWG_CNT_W+1:0] hi;
        begin
            lo = {2'b00, base} + {2'b00, offs};
            hi = lo + {2'b00, len};
            in_span = ({2'b00, pos} >= lo) && ({2'b00, pos} < hi);
        end
    endfunction

    // Heights are taken as lines per field in frame mode, since the line
    // counter supplied is the field line count.
    assign video1_line_hit = in_span(pixel_line, {4'h0, eff_base_y},
        {4'h0, video1_line_offset}, {2'b00, video1_line_height});
    assign bitmap0_hit =
        in_span(pixel_column, {3'h0, horizontal_base_reference},
                {3'h0, bitmap0_pixel_offset},
                {1'b0, bitmap0_pixel_width}) &&
        in_span(pixel_line, {4'h0, eff_base_y},
                {4'h0, bitmap0_line_offset},
                {2'b00, bitmap0_line_height});
    assign bitmap1_hit =
        in_span(pixel_column, {3'h0, horizontal_base_reference},
                {3'h0, bitmap1_pixel_offset},
                {1'b0, bitmap1_pixel_width}) &&
        in_span(pixel_line, {4'h0, eff_base_y},
                {4'h0, bitmap1_line_offset},
                {2'b00, bitmap1_line_height});
    assign cursor_hit =
        in_span(pixel_column, {3'h0, horizontal_base_reference},
                {3'h0, cursor_pixel_offset},
                {1'b0, cursor_pixel_width}) &&
        in_span(pixel_line, {4'h0, eff_base_y},
                {4'h0, cursor_line_offset},
                {2'b00, cursor_line_height});

    // Only the addressed field takes the write; the upper bits of the
    // write data have no place to go, so reserved bits stay zero.
    always @*
    begin
        next_v1_ys  = v1_ys;
        next_v1_w   = v1_w;
        next_v1_h   = v1_h;
        next_b0_xs  = b0_xs;
        next_b0_ys  = b0_ys;
        next_b0_w   = b0_w;
        next_b0_h   = b0_h;
        next_b1_xs  = b1_xs;
        next_b1_ys  = b1_ys;
        next_b1_w   = b1_w;
        next_b1_h   = b1_h;
        next_cu_xs  = cu_xs;
        next_cu_ys  = cu_ys;
        next_cu_w   = cu_w;
        next_cu_h   = cu_h;
        next_base_x = base_x;

        if (reg_write)
        begin
            case (reg_addr)
                `OWG_V1_YSTART:  next_v1_ys  = reg_wdata[8:0];
                `OWG_V1_WIDTH:   next_v1_w   = reg_wdata[11:0];
                `OWG_V1_HEIGHT:  next_v1_h   = reg_wdata[10:0];
                `OWG_B0_XSTART:  next_b0_xs  = reg_wdata[9:0];
                `OWG_B0_YSTART:  next_b0_ys  = reg_wdata[8:0];
                `OWG_B0_WIDTH:   next_b0_w   = reg_wdata[11:0];
                `OWG_B0_HEIGHT:  next_b0_h   = reg_wdata[10:0];
                `OWG_B1_XSTART:  next_b1_xs  = reg_wdata[9:0];
                `OWG_B1_YSTART:  next_b1_ys  = reg_wdata[8:0];
                `OWG_B1_WIDTH:   next_b1_w   = reg_wdata[11:0];
                `OWG_B1_HEIGHT:  next_b1_h   = reg_wdata[10:0];
                `OWG_CUR_XSTART: next_cu_xs  = reg_wdata[9:0];
                `OWG_CUR_YSTART: next_cu_ys  = reg_wdata[8:0];
                `OWG_CUR_WIDTH:  next_cu_w   = reg_wdata[11:0];
                `OWG_CUR_HEIGHT: next_cu_h   = reg_wdata[10:0];
                `OWG_BASE_X:     next_base_x = reg_wdata[9:0];
                default:         next_base_x = base_x;
            endcase
        end
    end

    // Software writes land in the pending copies; upper bits are dropped.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            v1_ys  <= 9'h000;
            v1_w   <= 12'h000;
            v1_h   <= 11'h000;
            b0_xs  <= 10'h000;
            b0_ys  <= 9'h000;
            b0_w   <= 12'h000;
            b0_h   <= 11'h000;
            b1_xs  <= 10'h000;
            b1_ys  <= 9'h000;
            b1_w   <= 12'h000;
            b1_h   <= 11'h000;
            cu_xs  <= 10'h000;
            cu_ys  <= 9'h000;
            cu_w   <= 12'h000;
            cu_h   <= 11'h000;
            base_x <= 10'h000;
        end
        else
        begin
            v1_ys  <= next_v1_ys;
            v1_w   <= next_v1_w;
            v1_h   <= next_v1_h;
            b0_xs  <= next_b0_xs;
            b0_ys  <= next_b0_ys;
            b0_w   <= next_b0_w;
            b0_h   <= next_b0_h;
            b1_xs  <= next_b1_xs;
            b1_ys  <= next_b1_ys;
            b1_w   <= next_b1_w;
            b1_h   <= next_b1_h;
            cu_xs  <= next_cu_xs;
            cu_ys  <= next_cu_ys;
            cu_w   <= next_cu_w;
            cu_h   <= next_cu_h;
            base_x <= next_base_x;
        end
    end

    // A write in the same cycle as vertical sync reaches the display only
    // at the following sync, since the pending value before that edge is
    // the one taken here.
    always @*
    begin
        next_video1_line_offset        = video1_line_offset;
        next_video1_pixel_width        = video1_pixel_width;
        next_video1_line_height        = video1_line_height;
        next_bitmap0_pixel_offset      = bitmap0_pixel_offset;
        next_bitmap0_line_offset       = bitmap0_line_offset;
        next_bitmap0_pixel_width       = bitmap0_pixel_width;
        next_bitmap0_line_height       = bitmap0_line_height;
        next_bitmap1_pixel_offset      = bitmap1_pixel_offset;
        next_bitmap1_line_offset       = bitmap1_line_offset;
        next_bitmap1_pixel_width       = bitmap1_pixel_width;
        next_bitmap1_line_height       = bitmap1_line_height;
        next_cursor_pixel_offset       = cursor_pixel_offset;
        next_cursor_line_offset        = cursor_line_offset;
        next_cursor_pixel_width        = cursor_pixel_width;
        next_cursor_line_height        = cursor_line_height;
        next_horizontal_base_reference = horizontal_base_reference;

        if (vertical_sync_event)
        begin
            next_video1_line_offset        = v1_ys;
            next_video1_pixel_width        = v1_w;
            next_video1_line_height        = v1_h;
            next_bitmap0_pixel_offset      = b0_xs;
            next_bitmap0_line_offset       = b0_ys;
            next_bitmap0_pixel_width       = b0_w;
            next_bitmap0_line_height       = b0_h;
            next_bitmap1_pixel_offset      = b1_xs;
            next_bitmap1_line_offset       = b1_ys;
            next_bitmap1_pixel_width       = b1_w;
            next_bitmap1_line_height       = b1_h;
            next_cursor_pixel_offset       = cu_xs;
            next_cursor_line_offset        = cu_ys;
            next_cursor_pixel_width        = cu_w;
            next_cursor_line_height        = cu_h;
            next_horizontal_base_reference = base_x;
        end
    end

    // Active copies change only at vertical sync, so a frame never tears.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            video1_line_offset        <= 9'h000;
            video1_pixel_width        <= 12'h000;
            video1_line_height        <= 11'h000;
            bitmap0_pixel_offset      <= 10'h000;
            bitmap0_line_offset       <= 9'h000;
            bitmap0_pixel_width       <= 12'h000;
            bitmap0_line_height       <= 11'h000;
            bitmap1_pixel_offset      <= 10'h000;
            bitmap1_line_offset       <= 9'h000;
            bitmap1_pixel_width       <= 12'h000;
            bitmap1_line_height       <= 11'h000;
            cursor_pixel_offset       <= 10'h000;
            cursor_line_offset        <= 9'h000;
            cursor_pixel_width        <= 12'h000;
            cursor_line_height        <= 11'h000;
            horizontal_base_reference <= 10'h000;
        end
        else
        begin
            video1_line_offset        <= next_video1_line_offset;
            video1_pixel_width        <= next_video1_pixel_width;
            video1_line_height        <= next_video1_line_height;
            bitmap0_pixel_offset      <= next_bitmap0_pixel_offset;
            bitmap0_line_offset       <= next_bitmap0_line_offset;
            bitmap0_pixel_width       <= next_bitmap0_pixel_width;
            bitmap0_line_height       <= next_bitmap0_line_height;
            bitmap1_pixel_offset      <= next_bitmap1_pixel_offset;
            bitmap1_line_offset       <= next_bitmap1_line_offset;
            bitmap1_pixel_width       <= next_bitmap1_pixel_width;
            bitmap1_line_height       <= next_bitmap1_line_height;
            cursor_pixel_offset       <= next_cursor_pixel_offset;
            cursor_line_offset        <= next_cursor_line_offset;
            cursor_pixel_width        <= next_cursor_pixel_width;
            cursor_line_height        <= next_cursor_line_height;
            horizontal_base_reference <= next_horizontal_base_reference;
        end
    end

    // Reads return the pending copy, zero-extended.
    always @*
    begin
        next_rdata = `OWG_RESET_VAL;
        case (reg_addr)
            `OWG_V1_YSTART:  next_rdata = {23'h0, v1_ys};
            `OWG_V1_WIDTH:   next_rdata = {20'h0, v1_w};
            `OWG_V1_HEIGHT:  next_rdata = {21'h0, v1_h};
            `OWG_B0_XSTART:  next_rdata = {22'h0, b0_xs};
            `OWG_B0_YSTART:  next_rdata = {23'h0, b0_ys};
            `OWG_B0_WIDTH:   next_rdata = {20'h0, b0_w};
            `OWG_B0_HEIGHT:  next_rdata = {21'h0, b0_h};
            `OWG_B1_XSTART:  next_rdata = {22'h0, b1_xs};
            `OWG_B1_YSTART:  next_rdata = {23'h0, b1_ys};
            `OWG_B1_WIDTH:   next_rdata = {20'h0, b1_w};
            `OWG_B1_HEIGHT:  next_rdata = {21'h0, b1_h};
            `OWG_CUR_XSTART: next_rdata = {22'h0, cu_xs};
            `OWG_CUR_YSTART: next_rdata = {23'h0, cu_ys};
            `OWG_CUR_WIDTH:  next_rdata = {20'h0, cu_w};
            `OWG_CUR_HEIGHT: next_rdata = {21'h0, cu_h};
            `OWG_BASE_X:     next_rdata = {22'h0, base_x};
            default:         next_rdata = `OWG_RESET_VAL;
        endcase
    end

    // Read data stand for one cycle after the strobe and are zero otherwise.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= `OWG_RESET_VAL;
        else if (reg_read)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= `OWG_RESET_VAL;
    end

endmodule
`default_nettype wire

// ---- verification/owg_geometry_sva.sv ----
// Checker for the window geometry register block.
`include "owg_consts.vh"
`default_nettype none
module owg_geometry_sva (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        vertical_sync_event,
    input wire logic [8:0]  vertical_base_reference,
    input wire logic [12:0] pixel_line,
    input wire logic [8:0]  video1_line_offset,
    input wire logic [10:0] video1_line_height,
    input wire logic [11:0] bitmap0_pixel_width,
    input wire logic [9:0]  bitmap1_pixel_offset,
    input wire logic [10:0] cursor_line_height,
    input wire logic        video1_line_hit
);
    timeunit 1ns / 1ps;
    logic [13:0] v1_lo;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Zero base counts as line one.
    assign v1_lo = (vertical_base_reference == 9'h0 ? 14'h1
        : {5'h0, vertical_base_reference}) + {5'h0, video1_line_offset};
    property p_load(a, v, m);
        reg_write && reg_addr == a ##1 vertical_sync_event && !reg_write
            |=> v == ($past(reg_wdata, 2) & m);
    endproperty
    a_b0w_load: assert property (
        p_load(`OWG_B0_WIDTH, bitmap0_pixel_width, 32'hfff))
        else $error("bitmap0 width not loaded at vsync");
    a_curh_load: assert property (
        p_load(`OWG_CUR_HEIGHT, cursor_line_height, 32'h7ff))
        else $error("cursor height not loaded at vsync");
    a_b1x_load: assert property (
        p_load(`OWG_B1_XSTART, bitmap1_pixel_offset, 32'h3ff))
        else $error("bitmap1 offset not loaded at vsync");
    a_v1y_load: assert property (
        p_load(`OWG_V1_YSTART, video1_line_offset, 32'h1ff))
        else $error("video1 offset not loaded at vsync");
    a_active_hold: assert property (!vertical_sync_event |=>
        $stable(bitmap0_pixel_width) && $stable(cursor_line_height))
        else $error("active copy changed without vsync");
    a_resv_zero: assert property (reg_read && reg_addr == `OWG_B0_WIDTH
        |=> reg_rdata[31:12] == 20'h0) else $error("reserved bits not zero");
    a_v1h_resv: assert property (reg_read && reg_addr == `OWG_V1_HEIGHT
        |=> reg_rdata[31:11] == 21'h0) else $error("height bits too wide");
    a_v1_hit: assert property (
        video1_line_hit == (pixel_line >= v1_lo
        && pixel_line < v1_lo + video1_line_height))
        else $error("video1 line hit wrong");
    c_vsync: cover property (vertical_sync_event);
    c_hit: cover property (video1_line_hit);
    c_read: cover property (reg_read && reg_addr == `OWG_CUR_HEIGHT);
endmodule
bind owg_window_geometry owg_geometry_sva u_sva (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .vertical_sync_event(vertical_sync_event),
    .vertical_base_reference(vertical_base_reference),
    .pixel_line(pixel_line), .video1_line_offset(video1_line_offset),
    .video1_line_height(video1_line_height),
    .bitmap0_pixel_width(bitmap0_pixel_width),
    .bitmap1_pixel_offset(bitmap1_pixel_offset),
    .cursor_line_height(cursor_line_height),
    .video1_line_hit(video1_line_hit));
`default_nettype wire

// ---- verification/owg_window_geometry_tb.sv ----
// Self-checking bench for the window geometry register block.
`include "owg_consts.vh"
`default_nettype none
module owg_window_geometry_tb;
    timeunit 1ns / 1ps;
    logic core_clk = 0, resetn = 0, reg_write = 0, reg_read = 0;
    logic vertical_sync_event = 0;
    logic [3:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, row_wd[16], row_exp[16];
    logic [31:0] msk4[4] = '{32'h1ff, 32'hfff, 32'h7ff, 32'h3ff};
    logic [8:0] vertical_base_reference = 0, video1_line_offset;
    logic [8:0] bitmap0_line_offset, bitmap1_line_offset, cursor_line_offset;
    logic [8:0] vb_tab[3] = '{9'h0, 9'h1, 9'h5};
    // Rows of register index and write data for the window hit test.
    logic [35:0] geo_row[13] = '{36'hf_0000_0018, 36'h3_0000_0000,
        36'h4_0000_0000, 36'h5_0000_0001, 36'h6_0000_0001,
        36'h7_0000_0005, 36'h8_0000_0002, 36'h9_0000_0002,
        36'ha_0000_0001, 36'hb_0000_0002, 36'hc_0000_0001,
        36'hd_0000_0003, 36'he_0000_0002};
    logic [12:0] pixel_column = 0, pixel_line = 0;
    logic [11:0] video1_pixel_width, bitmap0_pixel_width;
    logic [11:0] bitmap1_pixel_width, cursor_pixel_width;
    logic [10:0] video1_line_height, bitmap0_line_height;
    logic [10:0] bitmap1_line_height, cursor_line_height;
    logic [9:0] bitmap0_pixel_offset, bitmap1_pixel_offset;
    logic [9:0] cursor_pixel_offset, horizontal_base_reference;
    logic video1_line_hit, bitmap0_hit, bitmap1_hit, cursor_hit;
    int errors = 0, samples_checked = 0, cycles = 0, lo;
    owg_window_geometry uut (
        .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .vertical_sync_event, .vertical_base_reference,
        .pixel_column, .pixel_line, .video1_line_offset, .video1_pixel_width,
        .video1_line_height, .bitmap0_pixel_offset, .bitmap0_line_offset,
        .bitmap0_pixel_width, .bitmap0_line_height, .bitmap1_pixel_offset,
        .bitmap1_line_offset, .bitmap1_pixel_width, .bitmap1_line_height,
        .cursor_pixel_offset, .cursor_line_offset, .cursor_pixel_width,
        .cursor_line_height, .horizontal_base_reference, .video1_line_hit,
        .bitmap0_hit, .bitmap1_hit, .cursor_hit);
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Write (when w is set) then pulse vsync in the very next cycle.
    task automatic wv(input logic [3:0] a, input logic [31:0] d, logic w);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= w;
        @(posedge core_clk);
        reg_write <= 1'b0;
        vertical_sync_event <= 1'b1;
        @(posedge core_clk);
        vertical_sync_event <= 1'b0;
        #1;
    endtask
    function automatic logic [31:0] act(input logic [3:0] a);
        case (a)
            0: act = video1_line_offset;
            1: act = video1_pixel_width;
            2: act = video1_line_height;
            3: act = bitmap0_pixel_offset;
            4: act = bitmap0_line_offset;
            5: act = bitmap0_pixel_width;
            6: act = bitmap0_line_height;
            7: act = bitmap1_pixel_offset;
            8: act = bitmap1_line_offset;
            9: act = bitmap1_pixel_width;
            10: act = bitmap1_line_height;
            11: act = cursor_pixel_offset;
            12: act = cursor_line_offset;
            13: act = cursor_pixel_width;
            14: act = cursor_line_height;
            15: act = horizontal_base_reference;
        endcase
    endfunction
    // True when p lies in the span that starts at lo and is n long.
    function automatic logic inw(input int p, lo, n);
        return p >= lo && p < lo + n;
    endfunction
    // Reads each row back and compares the active copy as well.
    task automatic sweep(input logic rz, az);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge core_clk);
            reg_addr <= i[3:0];
            reg_read <= 1'b1;
            @(posedge core_clk);
            reg_read <= 1'b0;
            #1 chk(reg_rdata, rz ? 32'h0 : row_exp[i]);
            chk(act(i[3:0]), az ? 32'h0 : row_exp[i]);
        end
    endtask
    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            row_wd[i] = 32'h5a5a_5000 + 32'h123 * i;
            row_exp[i] = row_wd[i] & msk4[i % 4];
        end
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        sweep(1, 1);
        for (int i = 0; i < 16; i++)
            wv(i[3:0], row_wd[i], 1'b0);
        $display("done: reset values");
        for (int i = 0; i < 16; i++)
        begin
            @(posedge core_clk);
            reg_addr <= i[3:0];
            reg_wdata <= row_wd[i];
            reg_write <= 1'b1;
            @(posedge core_clk);
            reg_write <= 1'b0;
        end
        sweep(0, 1);
        wv(4'h0, 32'h0, 1'b0);
        sweep(0, 0);
        $display("done: load at vsync");
        @(posedge core_clk);
        reg_addr <= `OWG_CUR_HEIGHT;
        reg_wdata <= 32'h0000_0123;
        reg_write <= 1'b1;
        vertical_sync_event <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        vertical_sync_event <= 1'b0;
        #1 chk(cursor_line_height, row_exp[14]);
        wv(4'h0, 32'h0, 1'b0);
        chk(cursor_line_height, 32'h123);
        wv(`OWG_B1_XSTART, 32'hffff_f2ff, 1'b1);
        chk(bitmap1_pixel_offset, 32'h2ff);
        wv(`OWG_B0_WIDTH, 32'hffff_fabc, 1'b1);
        chk(bitmap0_pixel_width, 32'habc);
        wv(`OWG_V1_HEIGHT, 32'hffff_f802, 1'b1);
        wv(`OWG_V1_YSTART, 32'hffff_fe03, 1'b1);
        chk(video1_line_offset, 32'h3);
        $display("done: vsync ordering");
        foreach (vb_tab[k])
            for (int ln = 0; ln < 12; ln++)
            begin
                @(posedge core_clk);
                vertical_base_reference <= vb_tab[k];
                pixel_line <= ln[12:0];
                @(negedge core_clk);
                lo = (vb_tab[k] == 9'h0 ? 1 : int'(vb_tab[k])) + 3;
                chk(video1_line_hit, ln >= lo && ln < lo + 2);
            end
        $display("done: line hit");
        @(posedge core_clk);
        vertical_base_reference <= 9'h000;
        foreach (geo_row[j])
            wv(geo_row[j][35:32], geo_row[j][31:0], 1'b1);
        for (int ln = 0; ln < 5; ln++)
            for (int col = 24; col < 32; col++)
            begin
                @(posedge core_clk);
                pixel_line <= ln[12:0];
                pixel_column <= col[12:0];
                @(negedge core_clk);
                chk(bitmap0_hit, inw(col, 24 + 0, 1) && inw(ln, 1 + 0, 1));
                chk(bitmap1_hit, inw(col, 24 + 5, 2) && inw(ln, 1 + 2, 1));
                chk(cursor_hit, inw(col, 24 + 2, 3) && inw(ln, 1 + 1, 2));
            end
        $display("done: window hit");
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        sweep(1, 1);
        $display("done: second reset");
        end_sim();
    end
endmodule
`default_nettype wire
